// ### sfg_gate.sv
// Device end: access gate and system registers of the SIMD/FP unit.
// Assumes a pipeline that offers one instruction per cycle and keeps
// the control-register copies (coproc_access_control, nonsecure_access_control, hyp_coproc_trap) current.
//
// What this block does
// - Reset leaves both extensions disabled, undefined
// - Software sets unit enable before operations
// - Enable clear: only privileged id/control moves pass
// - Access needs grant for both coprocessors
// - Non-secure use needs both access bits set
// - Hyp use needs both trap bits clear
// - Short-vector operations are always undefined
// - Short-vector rejection leaves deferred flag unchanged
// - No asynchronous floating-point exceptions ever
// - Scalar operations run fully in hardware
// - Three configurations: full, FP only, none
// - Feature registers read-only with fixed values
// - Status and exception control reset zero
// - Identity register read-only, 32-bit code
// - Software never touches capture registers
// - Both coprocessors get identical permissions
// - Secure setup: access, barrier, then enable
// - Non-secure setup precedes access and enable
// - Hyp setup clears traps before enable
// - Id registers reachable by system-register moves
// - Rounding field selects four rounding modes
`timescale 1ns/1ps
`default_nettype none
`include "sfg_defs.svh"
module sfg_gate
   import sfg_pkg::*;
#(
   parameter sfg_cfg_t    CFG   = SFG_CFG_FULL,
   parameter logic [31:0] IDENT = `SFG_IDENT_DEFAULT  // Arbitrary value
) (
   input  wire logic     clk_sys_i,
   input  wire logic     sys_rst_i,
   sfg_link_if.gate      link,
   output logic          unit_enabled_o,
   output sfg_round_t    rounding_select_o,
   output logic [31:0]   fp_status_control_o
);

   // ************************************************************
   // State
   // ************************************************************
   logic [31:0] fp_status_control_ff;
   logic [31:0] fp_exception_control_ff;
   logic [31:0] rdata_ff;
   logic        rvalid_ff;

   // ************************************************************
   // Permission decode
   // ************************************************************
   // configuration presence
   wire fp_present   = (CFG != SFG_CFG_NONE);
   wire simd_present = (CFG == SFG_CFG_FULL);
   wire unit_enable_bit = fp_exception_control_ff[`SFG_EXC_EN_BIT];

   wire [1:0] perm_ten    = link.coproc_access_control[`SFG_COPROCESSOR_TEN_LO +: 2];
   wire [1:0] perm_eleven = link.coproc_access_control[`SFG_COPROCESSOR_ELEVEN_LO +: 2];
   wire grant_ten    = link.priv ? perm_ten[0]    : (perm_ten == 2'h3);
   wire grant_eleven = link.priv ? perm_eleven[0] : (perm_eleven == 2'h3);
   wire coproc_access_control_ok     = grant_ten && grant_eleven;

   wire ns_ok = !link.nonsec ||
                (link.nonsecure_access_control[`SFG_NS_COPROCESSOR_TEN_BIT] && link.nonsecure_access_control[`SFG_NS_COPROCESSOR_ELEVEN_BIT]);

   wire hyp_ok = !link.hyp ||
                 (!link.hyp_coproc_trap[`SFG_TRAP_COPROCESSOR_TEN_BIT] && !link.hyp_coproc_trap[`SFG_TRAP_COPROCESSOR_ELEVEN_BIT]);

   // SIMD disable bits: the secure one, the non-secure one, and hyp trap
   wire simd_blocked = link.coproc_access_control[`SFG_SIMD_DIS_BIT] ||
                       (link.nonsec && link.nonsecure_access_control[`SFG_NS_SIMD_DIS_BIT]) ||
                       (link.hyp && link.hyp_coproc_trap[`SFG_TRAP_SIMD_BIT]);
   wire access_ok = fp_present && coproc_access_control_ok && ns_ok && hyp_ok;

   wire sel_exc   = (link.sel == `SFG_SEL_EXC_CTRL);
   wire sel_ident = (link.sel == `SFG_SEL_IDENT);
   wire sel_feat  = (link.sel == `SFG_SEL_FEAT_ONE) || (link.sel == `SFG_SEL_FEAT_ZERO);
   wire is_move_to = (link.op == SFG_OP_MOVE_TO);
   wire is_move_fr = (link.op == SFG_OP_MOVE_FR);
   wire disabled_ok = link.priv &&
                      ((is_move_to && (sel_exc || sel_ident)) ||
                       (is_move_fr && (sel_exc || sel_ident || sel_feat)));

   // Identity and feature registers need PL1 even when enabled
   wire sel_priv_only = sel_ident || sel_feat || sel_exc;
   wire move_priv_ok  = !((is_move_to || is_move_fr) && sel_priv_only && !link.priv);

   // short vectors when stride or length nonzero
   wire vec_mode = (fp_status_control_ff[`SFG_STRIDE_LO +: 2] != 2'h0) ||
                   (fp_status_control_ff[`SFG_LEN_LO +: 3] != 3'h0);
   wire shortv   = (link.op == SFG_OP_SHORTV) ||
                   ((link.op == SFG_OP_SCALAR) && vec_mode);

   wire enable_ok = unit_enable_bit || disabled_ok;
   wire op_ok = (link.op == SFG_OP_SIMD) ? (simd_present && !simd_blocked) : 1'b1;

   // all reporting is synchronous to this decode
   // scalar ops pass regardless of rounding/flush/NaN settings
   wire allowed = access_ok && enable_ok && op_ok && move_priv_ok && !shortv;
   assign link.undef  = link.issue && !allowed;
   assign link.accept = link.issue && allowed;

   // ************************************************************
   // Register writes
   // ************************************************************
   // capture selectors decode to nothing
   wire wr_go     = link.accept && is_move_to;
   wire wr_status = wr_go && (link.sel == `SFG_SEL_STATUS);
   wire wr_exc    = wr_go && sel_exc;

   // Without SIMD, the saturation bit reads as zero
   wire [31:0] status_mask = simd_present ? 32'hFFFFFFFF : 32'hF7FFFFFF;

   // deferred flag written only by software, never by rejection
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fp_status_control_ff    <= `SFG_STATUS_RST;
         fp_exception_control_ff <= `SFG_EXC_CTRL_RST;
      end else begin
         if (wr_status) begin
            fp_status_control_ff <= link.wdata & status_mask;
         end
         if (wr_exc) begin
            fp_exception_control_ff <= link.wdata;
         end
      end
   end

   // ************************************************************
   // Register reads
   // ************************************************************
   // fixed feature values per configuration
   wire [31:0] feat_one  = !fp_present   ? `SFG_FEAT_NONE :
                           simd_present  ? `SFG_FEAT_ONE_FULL : `SFG_FEAT_ONE_NO_SIMD;
   wire [31:0] feat_zero = fp_present ? `SFG_FEAT_ZERO_FULL : `SFG_FEAT_NONE;

   logic [31:0] nxt_rdata;
   always_comb begin
      unique case (link.sel)
         `SFG_SEL_IDENT:     nxt_rdata = IDENT;
         `SFG_SEL_STATUS:    nxt_rdata = fp_status_control_ff;
         `SFG_SEL_FEAT_ONE:  nxt_rdata = feat_one;
         `SFG_SEL_FEAT_ZERO: nxt_rdata = feat_zero;
         `SFG_SEL_EXC_CTRL:  nxt_rdata = fp_exception_control_ff;
         default:            nxt_rdata = 32'h00000000;
      endcase
   end

   // Read data registered one cycle after the accepted move
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_ff  <= 32'h00000000;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= link.accept && is_move_fr;
         if (link.accept && is_move_fr) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   assign link.rdata  = rdata_ff;
   assign link.rvalid = rvalid_ff;

   // rounding field out to the datapath
   assign rounding_select_o   = sfg_round_t'(fp_status_control_ff[`SFG_ROUND_LO +: 2]);
   assign unit_enabled_o      = unit_enable_bit;
   assign fp_status_control_o = fp_status_control_ff;

endmodule
`default_nettype wire

// ### sfg_defs.svh
// Constants for the SIMD / floating-point access gate.
// Included by the package and by both ends; definitions only.
`ifndef SFG_DEFS_SVH
`define SFG_DEFS_SVH

// Register selector codes on the system-register move path
`define SFG_SEL_IDENT         3'h0
`define SFG_SEL_STATUS        3'h1
`define SFG_SEL_FEAT_ONE      3'h2
`define SFG_SEL_FEAT_ZERO     3'h3
`define SFG_SEL_EXC_CTRL      3'h4
`define SFG_SEL_CAPT_ONE      3'h5
`define SFG_SEL_CAPT_TWO      3'h6

// Reset and fixed values
`define SFG_STATUS_RST        32'h00000000
`define SFG_EXC_CTRL_RST      32'h00000000
`define SFG_FEAT_ONE_FULL     32'h11111111
`define SFG_FEAT_ONE_NO_SIMD  32'h11000011
`define SFG_FEAT_ZERO_FULL    32'h10110222
`define SFG_FEAT_NONE         32'h00000000
`define SFG_IDENT_DEFAULT     32'h5A5A0000
`define SFG_UNIT_EN_VALUE     32'h40000000
`define SFG_SECURE_ACCESS     32'h00F00000

// Field positions
`define SFG_EXC_EN_BIT        30
`define SFG_EXC_DEX_BIT       29
`define SFG_ROUND_LO          22
`define SFG_STRIDE_LO         20
`define SFG_LEN_LO            16
`define SFG_COPROCESSOR_TEN_LO           20
`define SFG_COPROCESSOR_ELEVEN_LO           22
`define SFG_SIMD_DIS_BIT      31
`define SFG_NS_COPROCESSOR_TEN_BIT       10
`define SFG_NS_COPROCESSOR_ELEVEN_BIT       11
`define SFG_NS_SIMD_DIS_BIT   15
`define SFG_TRAP_COPROCESSOR_TEN_BIT     10
`define SFG_TRAP_COPROCESSOR_ELEVEN_BIT     11
`define SFG_TRAP_SIMD_BIT     15

`endif

// ### sfg_pkg.sv
// Types shared by both ends of the access gate.
// Expects sfg_defs.svh on the include path.
`include "sfg_defs.svh"
package sfg_pkg;
   // Extension combinations the unit can be built with
   typedef enum logic [1:0] {
      SFG_CFG_FULL    = 2'h0,
      SFG_CFG_FP_ONLY = 2'h1,
      SFG_CFG_NONE    = 2'h2
   } sfg_cfg_t;

   // Rounding choices of the status/control register
   typedef enum logic [1:0] {
      SFG_RND_NEAREST = 2'h0,
      SFG_RND_PLUS    = 2'h1,
      SFG_RND_MINUS   = 2'h2,
      SFG_RND_ZERO    = 2'h3
   } sfg_round_t;

   // Kind of instruction offered to the gate
   typedef enum logic [2:0] {
      SFG_OP_SCALAR  = 3'h0,
      SFG_OP_SIMD    = 3'h1,
      SFG_OP_SHORTV  = 3'h2,
      SFG_OP_MOVE_TO = 3'h3,
      SFG_OP_MOVE_FR = 3'h4,
      SFG_OP_VCMP    = 3'h5
   } sfg_op_t;
endpackage

// ### sfg_link_if.sv
// Carrier between the pipeline end and the gate end.
// Both ends share clk_sys_i; the testbench instantiates this.
`timescale 1ns/1ps
`default_nettype none
interface sfg_link_if (
   input wire logic clk_sys_i
);
   import sfg_pkg::*;
   logic        issue;       // Instruction offered this cycle
   sfg_op_t     op;          // Instruction kind
   logic [2:0]  sel;         // System register selector
   logic [31:0] wdata;       // Move-to data
   logic        priv;        // Privileged (PL1 or higher)
   logic        nonsec;      // Non-secure state
   logic        hyp;         // Hyp mode
   logic [31:0] coproc_access_control;       // Coprocessor access control
   logic [31:0] nonsecure_access_control;       // Non-secure access control
   logic [31:0] hyp_coproc_trap;       // Hyp coprocessor trap
   logic        undef;       // Undefined-instruction indication
   logic        accept;      // Instruction may execute
   logic [31:0] rdata;       // Move-from data
   logic        rvalid;      // Move-from data valid

   modport gate (
      input  issue, op, sel, wdata, priv, nonsec, hyp, coproc_access_control, nonsecure_access_control, hyp_coproc_trap,
      output undef, accept, rdata, rvalid
   );
   modport pipe (
      output issue, op, sel, wdata, priv, nonsec, hyp, coproc_access_control, nonsecure_access_control, hyp_coproc_trap,
      input  undef, accept, rdata, rvalid
   );
endinterface
`default_nettype wire

// ### sfg_pipe.sv
// Far end: pipeline side that offers instructions and holds the
// control-register copies that software programs.
// Assumes the user drives one request per cycle at most.
`timescale 1ns/1ps
`default_nettype none
`include "sfg_defs.svh"
module sfg_pipe
   import sfg_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   sfg_link_if.pipe         link,
   input  wire logic        issue_i,
   input  wire sfg_op_t     op_i,
   input  wire logic [2:0]  sel_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        priv_i,
   input  wire logic        nonsec_i,
   input  wire logic        hyp_i,
   input  wire logic        coproc_access_control_wr_i,
   input  wire logic        nonsecure_access_control_wr_i,
   input  wire logic        hyp_coproc_trap_wr_i,
   output logic             undef_o,
   output logic             accept_o,
   output logic [31:0]      rdata_o,
   output logic             rvalid_o
);

   // ************************************************************
   // Control copies
   // ************************************************************
   logic [31:0] coproc_access_control_ff;
   logic [31:0] nonsecure_access_control_ff;
   logic [31:0] hyp_coproc_trap_ff;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         coproc_access_control_ff <= 32'h00000000;
         nonsecure_access_control_ff <= 32'h00000000;
         hyp_coproc_trap_ff <= 32'h00000000;
      end else begin
         if (coproc_access_control_wr_i) coproc_access_control_ff <= wdata_i;
         if (nonsecure_access_control_wr_i) nonsecure_access_control_ff <= wdata_i;
         if (hyp_coproc_trap_wr_i) hyp_coproc_trap_ff <= wdata_i;
      end
   end

   // ************************************************************
   // Request path
   // ************************************************************
   // user supplies enable write, avoids capture selectors
   assign link.issue  = issue_i;
   assign link.op     = op_i;
   assign link.sel    = sel_i;
   assign link.wdata  = wdata_i;
   assign link.priv   = priv_i;
   assign link.nonsec = nonsec_i;
   assign link.hyp    = hyp_i;
   assign link.coproc_access_control  = coproc_access_control_ff;
   assign link.nonsecure_access_control  = nonsecure_access_control_ff;
   assign link.hyp_coproc_trap  = hyp_coproc_trap_ff;

   assign undef_o  = link.undef;
   assign accept_o = link.accept;
   assign rdata_o  = link.rdata;
   assign rvalid_o = link.rvalid;

endmodule
`default_nettype wire

// ### sfg_link_properties.sv
// Concurrent checks on the link between pipeline end and gate end.
// Assumes full configuration and the default identity value.
`timescale 1ns/1ps
`default_nettype none
module sfg_link_properties
   import sfg_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        sys_rst_i,
   input wire logic        issue,
   input wire sfg_op_t     op,
   input wire logic [2:0]  sel,
   input wire logic        nonsec,
   input wire logic        hyp,
   input wire logic [31:0] coproc_access_control,
   input wire logic [31:0] nonsecure_access_control,
   input wire logic [31:0] hyp_coproc_trap,
   input wire logic        undef,
   input wire logic        accept,
   input wire logic [31:0] rdata,
   input wire logic        rvalid
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   verdict_one_hot_a: assert property (issue |-> (undef ^ accept))
      else $error("verdict not exactly one of undef and accept");
   idle_quiet_a: assert property (!issue |-> !undef && !accept)
      else $error("verdict shown without an instruction");
   shortv_undef_a: assert property (issue && op == SFG_OP_SHORTV |-> undef)
      else $error("short-vector operation not rejected");
   grant_needed_a: assert property (issue && (coproc_access_control[21:20] == 2'h0 || coproc_access_control[23:22] == 2'h0) |-> undef)
      else $error("access passed without coprocessor grant");
   nonsec_deny_a: assert property (issue && nonsec && !(nonsecure_access_control[10] && nonsecure_access_control[11]) |-> undef)
      else $error("non-secure access passed without access bits");
   hyp_trap_a: assert property (issue && hyp && (hyp_coproc_trap[10] || hyp_coproc_trap[11]) |-> undef)
      else $error("hyp access passed with trap bits set");
   feat_zero_rd_a: assert property (issue && accept && op == SFG_OP_MOVE_FR && sel == 3'h3
      |=> rvalid && rdata == 32'h10110222)
      else $error("feature zero read wrong");
   feat_one_rd_a: assert property (issue && accept && op == SFG_OP_MOVE_FR && sel == 3'h2
      |=> rvalid && rdata == 32'h11111111)
      else $error("feature one read wrong");
   rvalid_cause_a: assert property (rvalid |-> $past(issue && accept && op == SFG_OP_MOVE_FR))
      else $error("read data valid without accepted move-from");
   rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
      else $error("read data changed without a read");

   // Main scenarios reached
   cover property (issue && accept && op == SFG_OP_MOVE_FR);
   cover property (issue && undef && op == SFG_OP_SHORTV);
   cover property (issue && accept && nonsec && op == SFG_OP_SCALAR);
endmodule
`default_nettype wire

// ### test_simd_fp_access_gate.sv
// Self-checking bench: pipeline end and gate end joined by the link.
// Assumes full configuration; moves only to selectors 0..4.
`timescale 1ns/1ps
`default_nettype none
module test_simd_fp_access_gate;
   import sfg_pkg::*;
   // ****************************************
   // Signals and model state
   // ****************************************
   localparam logic [31:0] ID_VAL = 32'h5A5A0000; // Arbitrary value
   logic clk_sys_i, sys_rst_i, issue_i, priv_i, nonsec_i, hyp_i;
   logic coproc_access_control_wr_i, nonsecure_access_control_wr_i, hyp_coproc_trap_wr_i, undef_o, accept_o, rvalid_o, unit_enabled_o;
   sfg_op_t     op_i;
   sfg_round_t  rounding_select_o;
   logic [2:0]  sel_i;
   logic [31:0] wdata_i, rdata_o, fp_status_control_o, st_m, coproc_access_control_m, nonsecure_access_control_m, hyp_coproc_trap_m;
   logic        en_m;
   int          num_errors, checks;
   logic [31:0] tbl [3][4] = '{'{32'h00F00000, 32'h00500000, 32'h80F00000, 32'h0},
      '{32'h00000C00, 32'h0, 32'h00008C00, 32'h00000400}, '{32'h0, 32'h00000C00, 32'h00008000, 32'h00000400}};

   sfg_link_if link (.clk_sys_i(clk_sys_i));
   sfg_gate #(.CFG(SFG_CFG_FULL), .IDENT(ID_VAL)) i_sfg_gate (.clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i), .link(link), .unit_enabled_o(unit_enabled_o),
      .rounding_select_o(rounding_select_o), .fp_status_control_o(fp_status_control_o));
   sfg_pipe i_sfg_pipe (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link),
      .issue_i(issue_i), .op_i(op_i), .sel_i(sel_i), .wdata_i(wdata_i), .priv_i(priv_i),
      .nonsec_i(nonsec_i), .hyp_i(hyp_i), .coproc_access_control_wr_i(coproc_access_control_wr_i), .nonsecure_access_control_wr_i(nonsecure_access_control_wr_i),
      .hyp_coproc_trap_wr_i(hyp_coproc_trap_wr_i), .undef_o(undef_o), .accept_o(accept_o), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o));
   sfg_link_properties i_sfg_link_properties (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .issue(link.issue), .op(link.op), .sel(link.sel), .nonsec(link.nonsec), .hyp(link.hyp),
      .coproc_access_control(link.coproc_access_control), .nonsecure_access_control(link.nonsecure_access_control), .hyp_coproc_trap(link.hyp_coproc_trap), .undef(link.undef),
      .accept(link.accept), .rdata(link.rdata), .rvalid(link.rvalid));

   // ****************************************
   // Expectations and drivers
   // ****************************************
   // Verdict worked out from bench copies of every control value
   function automatic logic want_undef(sfg_op_t o, logic [2:0] s, logic p, n, h);
      logic g, sys_ok;
      g = p ? (coproc_access_control_m[20] & coproc_access_control_m[22]) : (&coproc_access_control_m[21:20] & &coproc_access_control_m[23:22]);
      sys_ok = p && ((o == SFG_OP_MOVE_TO && (s == 3'h0 || s == 3'h4)) ||
         (o == SFG_OP_MOVE_FR && s != 3'h1));
      return !g || (n && !(nonsecure_access_control_m[10] && nonsecure_access_control_m[11])) || (h && (hyp_coproc_trap_m[10] || hyp_coproc_trap_m[11]))
         || (o == SFG_OP_SIMD && (coproc_access_control_m[31] || (n && nonsecure_access_control_m[15]) || (h && hyp_coproc_trap_m[15])))
         || (!en_m && !sys_ok) || o == SFG_OP_SHORTV
         || (o == SFG_OP_SCALAR && (st_m[21:20] != 2'h0 || st_m[18:16] != 3'h0));
   endfunction

   function automatic logic [31:0] exp_rd(logic [2:0] s);
      case (s)
         3'h0: return ID_VAL;
         3'h1: return st_m;
         3'h2: return 32'h11111111;
         3'h3: return 32'h10110222;
         default: return {1'b0, en_m, 30'h0};
      endcase
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Loads one control copy; the pipe takes it at the second edge
   task automatic ctl(input int w, input logic [31:0] v);
      @(posedge clk_sys_i);
      wdata_i <= v; coproc_access_control_wr_i <= (w == 0); nonsecure_access_control_wr_i <= (w == 1); hyp_coproc_trap_wr_i <= (w == 2);
      @(posedge clk_sys_i);
      {coproc_access_control_wr_i, nonsecure_access_control_wr_i, hyp_coproc_trap_wr_i} <= 3'h0;
      if (w == 0) coproc_access_control_m = v; else if (w == 1) nonsecure_access_control_m = v; else hyp_coproc_trap_m = v;
   endtask

   // One instruction; verdict sampled mid-cycle, read data one cycle on
   task automatic instr(input sfg_op_t o, input logic [2:0] s, input logic [31:0] d,
                        input logic p, input logic n, input logic h);
      logic u;
      u = want_undef(o, s, p, n, h);
      @(posedge clk_sys_i);
      issue_i <= 1'b1; op_i <= o; sel_i <= s; wdata_i <= d; priv_i <= p; nonsec_i <= n; hyp_i <= h;
      @(negedge clk_sys_i);
      check(undef_o, u);
      check(accept_o, !u);
      if (!u && o == SFG_OP_MOVE_TO && s == 3'h4) en_m = d[30];
      if (!u && o == SFG_OP_MOVE_TO && s == 3'h1) st_m = d;
      @(posedge clk_sys_i);
      issue_i <= 1'b0;
      @(negedge clk_sys_i);
      check(unit_enabled_o, en_m);
      check(rounding_select_o, st_m[23:22]);
      check(fp_status_control_o, st_m);
      check(rvalid_o, !u && o == SFG_OP_MOVE_FR);
      if (!u && o == SFG_OP_MOVE_FR) begin
         check(rdata_o, exp_rd(s));
      end
   endtask

   task automatic tally_and_finish;
      if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ****************************************
   // Clock, watchdog and sequence
   // ****************************************
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   // Run needs about 1250 cycles; cut a hang well beyond that
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      logic p, n, h;
      logic [2:0] s;
      logic [31:0] d;
      sfg_op_t o;
      int r;
      {issue_i, priv_i, nonsec_i, hyp_i, coproc_access_control_wr_i, nonsecure_access_control_wr_i, hyp_coproc_trap_wr_i} = 7'h0;
      op_i = SFG_OP_SCALAR; sel_i = 3'h0; wdata_i = 32'h0; sys_rst_i = 1'b1;
      {st_m, coproc_access_control_m, nonsecure_access_control_m, hyp_coproc_trap_m, en_m} = '0;
      num_errors = 0; checks = 0;
      void'($urandom(79824));
      repeat (8) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      // After reset everything is rejected, even privileged reads
      instr(SFG_OP_SCALAR, 3'h0, 32'h0, 1'b1, 1'b0, 1'b0);
      instr(SFG_OP_MOVE_FR, 3'h3, 32'h0, 1'b1, 1'b0, 1'b0);
      ctl(0, 32'h00F00000);
      // Enable clear: only identity, features and exception control pass
      for (int i = 0; i < 5; i++) instr(SFG_OP_MOVE_FR, i[2:0], 32'h0, 1'b1, 1'b0, 1'b0);
      instr(SFG_OP_SIMD, 3'h0, 32'h0, 1'b1, 1'b0, 1'b0);
      instr(SFG_OP_MOVE_TO, 3'h4, 32'h40000000, 1'b1, 1'b0, 1'b0);
      instr(SFG_OP_MOVE_TO, 3'h0, 32'hFFFFFFFF, 1'b1, 1'b0, 1'b0);
      instr(SFG_OP_MOVE_FR, 3'h0, 32'h0, 1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         instr(SFG_OP_MOVE_TO, 3'h1, 32'(i) << 22, 1'b0, 1'b0, 1'b0);
         instr(SFG_OP_MOVE_FR, 3'h1, 32'h0, 1'b1, 1'b0, 1'b0);
      end
      // Vector rejection leaves the deferred flag clear
      instr(SFG_OP_SHORTV, 3'h0, 32'h0, 1'b1, 1'b0, 1'b0);
      instr(SFG_OP_MOVE_FR, 3'h4, 32'h0, 1'b1, 1'b0, 1'b0);
      for (int k = 0; k < 600; k++) begin
         r = $urandom_range(0, 9);
         if (r < 3) begin
            ctl(r, tbl[r][$urandom_range(0, 3)]);
         end else begin
            h = 1'($urandom); n = h | 1'($urandom); p = h | 1'($urandom);
            o = sfg_op_t'($urandom_range(0, 5)); s = 3'($urandom_range(0, 4)); d = $urandom;
            if (o == SFG_OP_MOVE_TO) begin
               s = $urandom_range(0, 1) ? 3'h1 : 3'h4;
               d = (s == 3'h1) ? (d & 32'h00F70000) : (d & 32'h40000000);
            end
            if ((o == SFG_OP_MOVE_TO || o == SFG_OP_MOVE_FR) && s != 3'h1) p = 1'b1;
            instr(o, s, d, p, n, h);
         end
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
